//--- design/fprf_top.sv
// floating-point coprocessor register file with vector sequencing and transfer ports
// assumes one core clock; arithmetic and divide pipes sit outside and write back here
//
// Operation
// [RULE1] thirty-two 32-bit registers in four banks of eight
// [RULE2] a register holds single or integer bits with no type tag
// [RULE3] even register plus next odd form one double, odd is upper
// [RULE4] vector indices wrap inside their bank of eight
// [RULE5] multiple loads and stores run linearly across banks
// [RULE6] length and step fields set element count and index increment
// [RULE7] transfers move register bits unchanged, same format as memory
// [RULE8] no operand type check; bits read by the instruction precision
// [RULE9] software must load a register before reading it
// [RULE10] integers are 32-bit unsigned or two's complement signed
// [RULE11] single: sign 31, exponent 30..23, fraction 22..0
// [RULE12] double upper word: sign 31, exponent 30..20, fraction 19..0
// [RULE13] vector operation accepted in one cycle, runs on afterwards
// [RULE14] vector, multiple transfer and divide pipes run concurrently
// [RULE15] divide unit has its own write port
// [RULE16] vector divide blocks multiply and divide pipes until last element
// [RULE17] control register transfers wait for earlier activity
// [RULE18] no branches; compare flags reach the core by flag transfer
// [RULE19] at most eight single or four double elements
// [RULE20] register number is four-bit field plus low bit; zero for double
// [RULE21] flag transfer copies N, C, Z, V to the core
// [RULE22] main and divide port writes in one cycle both commit
`timescale 1ns/10ps
`default_nettype none
`include "fprf_cfg.svh"
module fprf_top
	import fprf_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// core transfer request
	input wire logic xfer_valid,
	output logic xfer_ready,
	input wire logic xfer_write,
	input wire fprf_xfer_t xfer_kind,
	input wire logic [3:0] xfer_field,
	input wire logic xfer_extra,
	input wire logic [31:0] xfer_wdata0,
	input wire logic [31:0] xfer_wdata1,
	// core transfer answer
	output logic xfer_rvalid,
	output logic [31:0] xfer_rdata0,
	output logic [31:0] xfer_rdata1,
	output logic operand_error,
	// short-vector issue
	input wire logic vec_valid,
	output logic vec_ready,
	input wire logic vec_is_dbl,
	input wire logic vec_is_div,
	input wire logic [4:0] vec_dst,
	input wire logic [4:0] vec_src_a,
	input wire logic [4:0] vec_src_b,
	// element issue to the arithmetic pipes
	output logic elem_valid,
	output logic elem_dbl,
	output logic elem_div,
	output logic [4:0] elem_dst,
	output logic [63:0] elem_opa,
	output logic [63:0] elem_opb,
	output logic elem_a_sign,
	output logic [10:0] elem_a_exp,
	output logic mac_div_busy,
	// multiple load and store
	input wire logic lsm_start,
	input wire logic lsm_load,
	input wire logic [4:0] lsm_base,
	input wire logic [5:0] lsm_count,
	output logic lsm_busy,
	input wire logic lsm_wvalid,
	input wire logic [31:0] lsm_wdata,
	output logic lsm_rvalid,
	output logic [31:0] lsm_rdata,
	// arithmetic write-back, main port
	input wire logic res_valid,
	input wire logic res_dbl,
	input wire logic [4:0] res_idx,
	input wire logic [63:0] res_data,
	// divide write-back, own port
	input wire logic ds_valid,
	input wire logic ds_dbl,
	input wire logic [4:0] ds_idx,
	input wire logic [63:0] ds_data,
	input wire logic ds_busy,
	// compare flags and flag transfer
	input wire logic cmp_valid,
	input wire logic [3:0] cmp_nzcv,
	input wire logic flag_xfer_valid,
	output logic flag_xfer_done,
	output logic [3:0] core_nzcv,
	// status and control word
	output logic [31:0] fp_status_control_reg
);
	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	logic [4:0] xfer_reg;
	logic xfer_take;
	logic xfer_dbl_kind;
	logic xfer_bad;
	logic vec_take;
	logic lsm_take;
	logic seq_busy;
	logic seq_last;
	logic [4:0] seq_dst;
	logic [4:0] seq_a;
	logic [4:0] seq_b;
	logic lsm_is_load;
	logic [4:0] lsm_idx;
	logic [5:0] lsm_left;
	logic lsm_beat;
	logic [5:0] room;
	logic [2:0] we_lo;
	logic [2:0] we_hi;
	logic [14:0] w_idx;
	logic [95:0] w_lo;
	logic [95:0] w_hi;
	logic [14:0] r_idx;
	logic [95:0] r_lo;
	logic [95:0] r_hi;
	logic rd_pend;
	fprf_xfer_t rd_kind;
	logic vec_div_run;

	// [RULE20] field plus low bit
	assign xfer_reg = fprf_regnum(xfer_field, xfer_extra);
	assign xfer_dbl_kind = (xfer_kind == X_LO) || (xfer_kind == X_HI) || (xfer_kind == X_DBL);
	// [RULE20] doubles need an even number
	assign xfer_bad = xfer_dbl_kind && xfer_extra;

	//------------------------------------------------------------
	// acceptance
	//------------------------------------------------------------
	// [RULE17] control moves serialise
	// the transfer port is shared with multiple load/store, so those stall host moves
	always_comb begin
		xfer_ready = !lsm_busy;
		if (xfer_kind == X_CTRL && (seq_busy || ds_busy || mac_div_busy || vec_valid)) begin
			xfer_ready = 1'b0;
		end
	end
	assign xfer_take = xfer_valid && xfer_ready;
	// [RULE13] one-cycle vector accept
	assign vec_ready = !seq_busy && !mac_div_busy;
	assign vec_take = vec_valid && vec_ready;
	// [RULE14] multiple transfers independent of vector
	assign lsm_take = lsm_start && !lsm_busy;
	assign lsm_beat = lsm_busy && (!lsm_is_load || lsm_wvalid);
	assign room = 6'(`FPRF_NREG) - {1'b0, lsm_base};

	//------------------------------------------------------------
	// status and control word and flags
	//------------------------------------------------------------
	// [RULE18] compare flags held here for the core
	// a compare in the same cycle as a control write wins the flag field
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fp_status_control_reg <= `FPRF_SCR_RESET;
		end else begin
			if (xfer_take && xfer_write && xfer_kind == X_CTRL) begin
				fp_status_control_reg <= xfer_wdata0;
			end
			if (cmp_valid) begin
				fp_status_control_reg[`FPRF_NZCV_LSB +: 4] <= cmp_nzcv;
			end
		end
	end

	// [RULE21] flag transfer copy
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_nzcv <= 4'h0;
			flag_xfer_done <= 1'b0;
		end else begin
			flag_xfer_done <= flag_xfer_valid;
			if (flag_xfer_valid) begin
				core_nzcv <= fp_status_control_reg[`FPRF_NZCV_LSB +: 4];
			end
		end
	end

	//------------------------------------------------------------
	// vector sequencing
	//------------------------------------------------------------
	// [RULE6] length and step from the control word
	fprf_seq u_seq (
		.clock(clock),
		.rst(rst),
		.start(vec_take),
		.dst(vec_dst),
		.src_a(vec_src_a),
		.src_b(vec_src_b),
		.len(fp_status_control_reg[`FPRF_LEN_LSB +: `FPRF_LEN_W]),
		.step(fp_status_control_reg[`FPRF_STEP_LSB +: `FPRF_STEP_W]),
		.is_dbl(vec_is_dbl),
		.busy(seq_busy),
		.elem_dst(seq_dst),
		.elem_a(seq_a),
		.elem_b(seq_b),
		.elem_last(seq_last)
	);

	// [RULE16] divide vector blocks pipes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vec_div_run <= 1'b0;
		end else if (vec_take) begin
			vec_div_run <= vec_is_div;
		end else if (seq_last) begin
			vec_div_run <= 1'b0;
		end
	end
	assign mac_div_busy = vec_div_run;

	// element outputs line up with the registered operand reads
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			elem_valid <= 1'b0;
			elem_dbl <= 1'b0;
			elem_div <= 1'b0;
			elem_dst <= 5'h00;
		end else begin
			elem_valid <= seq_busy;
			elem_dst <= seq_dst;
			if (vec_take) begin
				elem_dbl <= vec_is_dbl;
				elem_div <= vec_is_div;
			end
		end
	end
	// [RULE3] odd word is upper half
	assign elem_opa = {r_hi[31:0], r_lo[31:0]};
	assign elem_opb = {r_hi[63:32], r_lo[63:32]};
	// [RULE8] fields taken by precision
	// [RULE11] single field positions
	// [RULE12] double upper-word positions
	assign elem_a_sign = elem_dbl ? r_hi[`FPRF_SIGN_BIT] : r_lo[`FPRF_SIGN_BIT];
	assign elem_a_exp = elem_dbl ? r_hi[`FPRF_DEXP_MSB:`FPRF_DEXP_LSB]
		: {3'h0, r_lo[`FPRF_SEXP_MSB:`FPRF_SEXP_LSB]};

	//------------------------------------------------------------
	// multiple load and store
	//------------------------------------------------------------
	// [RULE5] linear, no wrap, clamped at top
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lsm_busy <= 1'b0;
			lsm_is_load <= 1'b0;
			lsm_idx <= 5'h00;
			lsm_left <= 6'h00;
		end else if (lsm_take) begin
			lsm_busy <= (lsm_count != 6'h00);
			lsm_is_load <= lsm_load;
			lsm_idx <= lsm_base;
			lsm_left <= (lsm_count > room) ? room : lsm_count;
		end else if (lsm_beat) begin
			lsm_idx <= lsm_idx + 5'h1;
			lsm_left <= lsm_left - 6'h1;
			if (lsm_left == 6'h1) begin
				lsm_busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lsm_rvalid <= 1'b0;
		end else begin
			lsm_rvalid <= lsm_beat && !lsm_is_load;
		end
	end
	assign lsm_rdata = r_lo[95:64];

	//------------------------------------------------------------
	// write ports
	//------------------------------------------------------------
	// [RULE22] three ports commit together
	// [RULE15] divide unit on port 2
	// [RULE7] bits stored unchanged
	always_comb begin
		we_lo = 3'h0;
		we_hi = 3'h0;
		w_idx = {ds_idx, xfer_reg, res_idx};
		w_lo = {ds_data[31:0], xfer_wdata0, res_data[31:0]};
		w_hi = {ds_data[63:32], xfer_wdata1, res_data[63:32]};
		we_lo[0] = res_valid;
		we_hi[0] = res_valid && res_dbl;
		we_lo[2] = ds_valid;
		we_hi[2] = ds_valid && ds_dbl;
		if (lsm_beat && lsm_is_load) begin
			we_lo[1] = 1'b1;
			w_idx[9:5] = lsm_idx;
			w_lo[63:32] = lsm_wdata;
		end else if (xfer_take && xfer_write && !xfer_bad) begin
			case (xfer_kind)
				X_SGL, X_LO: we_lo[1] = 1'b1;
				X_HI: begin
					we_hi[1] = 1'b1;
					w_hi[63:32] = xfer_wdata0;
				end
				X_DBL, X_PAIR: begin
					we_lo[1] = 1'b1;
					we_hi[1] = 1'b1;
				end
				default: we_lo[1] = 1'b0;
			endcase
		end
	end

	// [RULE1] thirty-two words, four banks
	// [RULE2] untagged 32-bit words
	fprf_mem u_mem (
		.clock(clock),
		.rst(rst),
		.we_lo(we_lo),
		.we_hi(we_hi),
		.w_idx(w_idx),
		.w_lo(w_lo),
		.w_hi(w_hi),
		.r_idx(r_idx),
		.r_lo(r_lo),
		.r_hi(r_hi)
	);
	assign r_idx = {(lsm_busy ? lsm_idx : xfer_reg), seq_b, seq_a};

	//------------------------------------------------------------
	// transfer reads: two cycles, second stage from flops
	//------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_pend <= 1'b0;
			rd_kind <= X_SGL;
			operand_error <= 1'b0;
		end else begin
			rd_pend <= xfer_take && !xfer_write && !xfer_bad;
			rd_kind <= xfer_kind;
			operand_error <= xfer_take && xfer_bad;
		end
	end

	// [RULE10] integers pass as plain words
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			xfer_rvalid <= 1'b0;
			xfer_rdata0 <= 32'h0;
			xfer_rdata1 <= 32'h0;
		end else begin
			xfer_rvalid <= rd_pend;
			if (rd_pend) begin
				xfer_rdata0 <= (rd_kind == X_HI) ? r_hi[95:64] : r_lo[95:64];
				xfer_rdata1 <= r_hi[95:64];
				if (rd_kind == X_CTRL) begin
					xfer_rdata0 <= fp_status_control_reg;
				end
			end
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_vec_issue;
		vec_valid && vec_ready;
	endsequence
	sequence s_div_issue;
		vec_valid && vec_ready && vec_is_div;
	endsequence

	a_vec_one_cycle: assert property (s_vec_issue |=> seq_busy && !vec_ready) // [RULE13]
		else $error("vector not started after accept");
	a_div_blocks: assert property ((vec_valid && vec_ready && vec_is_div) || (mac_div_busy
		&& !seq_last) |=> mac_div_busy) // [RULE16]
		else $error("divide pipes freed early");
	a_div_freed: assert property (seq_last |=> !mac_div_busy) // [RULE16]
		else $error("divide pipes held after last element");
	a_elem_limit: assert property (s_vec_issue |=> ##[1:8] !seq_busy) // [RULE19]
		else $error("too many vector elements");
	a_ctrl_serial: assert property (xfer_take && xfer_kind == X_CTRL |-> !seq_busy && !ds_busy) // [RULE17]
		else $error("control transfer not serialised");
	a_lsm_linear: assert property (lsm_beat && lsm_left != 6'h1 |=> lsm_idx == $past(lsm_idx) + 5'h1) // [RULE5]
		else $error("multiple transfer index not linear");
	a_read_latency: assert property (xfer_take && !xfer_write && !xfer_bad |-> ##2 xfer_rvalid) // [RULE7]
		else $error("transfer read answer late");
	a_flag_copy: assert property (flag_xfer_valid |=> flag_xfer_done
		&& core_nzcv == $past(fp_status_control_reg[31:28])) // [RULE21]
		else $error("flags not copied to core");
	a_dbl_even: assert property (xfer_take && xfer_dbl_kind && xfer_extra |=> operand_error) // [RULE20]
		else $error("odd double number not flagged");
	a_ports_both: assert property (res_valid && ds_valid |-> we_lo[0] && we_lo[2]) // [RULE22]
		else $error("simultaneous write dropped");
endmodule : fprf_top
`default_nettype wire

//--- design/fprf_cfg.svh
// constants of the floating-point register file: sizes, field positions, counts
// assumes nothing; included by the package and the design modules
`ifndef FPRF_CFG_SVH
`define FPRF_CFG_SVH
`define FPRF_NREG 32
`define FPRF_IDX_W 5
`define FPRF_BANK_W 3
`define FPRF_WORD_W 32
`define FPRF_SCR_RESET 32'h0000_0000
`define FPRF_LEN_LSB 16
`define FPRF_LEN_W 3
`define FPRF_STEP_LSB 20
`define FPRF_STEP_W 2
`define FPRF_STEP_TWO 2'h3
`define FPRF_NZCV_LSB 28
`define FPRF_MAX_SGL 4'h8
`define FPRF_MAX_DBL 4'h4
`define FPRF_SIGN_BIT 31
`define FPRF_SEXP_MSB 30
`define FPRF_SEXP_LSB 23
`define FPRF_DEXP_MSB 30
`define FPRF_DEXP_LSB 20
`define FPRF_CNT_W 6
`endif

//--- design/fprf_pkg.sv
// types and shared decode functions of the floating-point register file
// assumes the constants header is on the include path
`include "fprf_cfg.svh"
package fprf_pkg;
	// kinds of core transfer
	typedef enum logic [2:0] {
		X_SGL = 3'h0,
		X_LO = 3'h1,
		X_HI = 3'h2,
		X_DBL = 3'h3,
		X_PAIR = 3'h4,
		X_CTRL = 3'h5
	} fprf_xfer_t;
	typedef enum logic [0:0] {
		S_IDLE = 1'h0,
		S_RUN = 1'h1
	} fprf_seq_state_t;
	// four-bit field plus one low bit forms the register number
	function automatic logic [4:0] fprf_regnum(input logic [3:0] field, input logic extra);
		return {field, extra};
	endfunction : fprf_regnum
	// advance inside the bank of eight, wrapping around
	function automatic logic [4:0] fprf_bank_next(input logic [4:0] idx, input logic [2:0] step);
		logic [2:0] low;
		low = idx[2:0] + step;
		return {idx[4:3], low};
	endfunction : fprf_bank_next
endpackage : fprf_pkg

//--- design/fprf_mem.sv
// storage of thirty-two words with three write ports and three registered read ports
// assumes the write ports never hit the same word in one cycle
`timescale 1ns/10ps
`default_nettype none
`include "fprf_cfg.svh"
module fprf_mem
	import fprf_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// write ports: arithmetic, transfer, divide; hi goes to idx+1
	input wire logic [2:0] we_lo,
	input wire logic [2:0] we_hi,
	input wire logic [14:0] w_idx,
	input wire logic [95:0] w_lo,
	input wire logic [95:0] w_hi,
	// read ports: operand a, operand b, transfer; hi reads idx+1
	input wire logic [14:0] r_idx,
	output logic [95:0] r_lo,
	output logic [95:0] r_hi
);
	logic [31:0] store [`FPRF_NREG];

	// no reset on storage: unread until software loads it
	always_ff @(posedge clock) begin
		for (int p = 0; p < 3; p++) begin
			if (we_lo[p]) begin
				store[w_idx[p*5 +: 5]] <= w_lo[p*32 +: 32];
			end
			if (we_hi[p]) begin
				store[5'(w_idx[p*5 +: 5] + 5'h1)] <= w_hi[p*32 +: 32];
			end
		end
	end

	// registered reads, bits unchanged
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r_lo <= '0;
			r_hi <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				r_lo[p*32 +: 32] <= store[r_idx[p*5 +: 5]];
				r_hi[p*32 +: 32] <= store[5'(r_idx[p*5 +: 5] + 5'h1)];
			end
		end
	end
endmodule : fprf_mem
`default_nettype wire

//--- design/fprf_seq.sv
// short-vector element sequencer: walks the element indices of one vector operation
// assumes start only while busy is low
`timescale 1ns/10ps
`default_nettype none
`include "fprf_cfg.svh"
module fprf_seq
	import fprf_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// start of a vector operation
	input wire logic start,
	input wire logic [4:0] dst,
	input wire logic [4:0] src_a,
	input wire logic [4:0] src_b,
	input wire logic [2:0] len,
	input wire logic [1:0] step,
	input wire logic is_dbl,
	// element issue
	output logic busy,
	output logic [4:0] elem_dst,
	output logic [4:0] elem_a,
	output logic [4:0] elem_b,
	output logic elem_last
);
	fprf_seq_state_t state;
	logic [3:0] left;
	logic [2:0] inc;
	logic [3:0] want;
	logic [3:0] cap;

	assign busy = (state == S_RUN);
	assign elem_last = busy && (left == 4'h1);
	// element count and index step from the control fields, clamped per precision
	// [RULE6] length and step fields
	// [RULE19] eight single, four double
	always_comb begin
		want = {1'b0, len} + 4'h1;
		cap = is_dbl ? `FPRF_MAX_DBL : `FPRF_MAX_SGL;
		inc = (step == `FPRF_STEP_TWO) ? 3'h2 : 3'h1;
		if (is_dbl) begin
			inc = {inc[1:0], 1'b0};
		end
		if (want > cap) begin
			want = cap;
		end
	end

	// [RULE4] bank circular walk
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			left <= 4'h0;
			elem_dst <= 5'h00;
			elem_a <= 5'h00;
			elem_b <= 5'h00;
		end else begin
			case (state)
				S_IDLE: begin
					if (start) begin
						state <= S_RUN;
						left <= want;
						elem_dst <= dst;
						elem_a <= src_a;
						elem_b <= src_b;
					end
				end
				S_RUN: begin
					left <= left - 4'h1;
					elem_dst <= fprf_bank_next(elem_dst, inc);
					elem_a <= fprf_bank_next(elem_a, inc);
					elem_b <= fprf_bank_next(elem_b, inc);
					if (left == 4'h1) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_bank_stays: assert property (busy && !elem_last |=> elem_dst[4:3] == $past(elem_dst[4:3]))
		else $error("vector index left its bank"); // [RULE4]
endmodule : fprf_seq
`default_nettype wire

//--- dv/fprf_host_model.sv
// host core model: issues register transfers into the file and collects the answers
// assumes it alone drives the transfer request port, on the core clock
`timescale 1ns/10ps
`default_nettype none
module fprf_host_model
	import fprf_pkg::*;
(
	// clock
	input wire logic clock,
	// transfer request
	output logic xfer_valid,
	input wire logic xfer_ready,
	output logic xfer_write,
	output fprf_xfer_t xfer_kind,
	output logic [3:0] xfer_field,
	output logic xfer_extra,
	output logic [31:0] xfer_wdata0,
	output logic [31:0] xfer_wdata1,
	// transfer answer
	input wire logic xfer_rvalid,
	input wire logic [31:0] xfer_rdata0,
	input wire logic [31:0] xfer_rdata1,
	input wire logic operand_error
);
	logic [31:0] loaded = 32'h0;
	// idle request at time zero
	initial begin
		xfer_valid = 1'b0;
		xfer_write = 1'b0;
		xfer_kind = X_SGL;
		xfer_field = 4'h0;
		xfer_extra = 1'b0;
		xfer_wdata0 = 32'h0;
		xfer_wdata1 = 32'h0;
	end
	// one transfer: held until taken, released data lines show inverted values
	task automatic xfer(input logic w, input fprf_xfer_t k, input logic [4:0] r,
		input logic [31:0] d0, input logic [31:0] d1,
		output logic [31:0] q0, output logic [31:0] q1, output logic e);
		int n;
		n = 0;
		q0 = 32'h0;
		q1 = 32'h0;
		e = 1'b0;
		if (!w && k != X_CTRL && !loaded[r]) $display("host reads unloaded register %0d", r);
		@(posedge clock);
		#1;
		xfer_valid = 1'b1;
		xfer_write = w;
		xfer_kind = k;
		xfer_field = r[4:1];
		xfer_extra = r[0];
		xfer_wdata0 = d0;
		xfer_wdata1 = d1;
		do @(negedge clock); while (!xfer_ready && ++n < 400);
		@(posedge clock);
		#1;
		xfer_valid = 1'b0;
		xfer_wdata0 = ~d0;
		xfer_wdata1 = ~d1;
		if (w && k != X_CTRL) loaded[r] = 1'b1;
		if (w && k != X_CTRL && k != X_SGL) loaded[5'(r + 5'h1)] = 1'b1;
		// answer window: error one edge on, read data two edges on
		repeat (3) begin
			@(negedge clock);
			if (xfer_rvalid) begin
				q0 = xfer_rdata0;
				q1 = xfer_rdata1;
			end
			e = e | operand_error;
		end
	endtask : xfer
endmodule : fprf_host_model
`default_nettype wire

//--- dv/fprf_top_tb.sv
// self-checking bench of the floating-point register file
// assumes the host model owns the transfer port; this bench drives all other inputs
`timescale 1ns/10ps
`default_nettype none
module fprf_top_tb
	import fprf_pkg::*;
;
	// ------------------
	// signals and design
	// ------------------
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic xfer_valid, xfer_ready, xfer_write, xfer_extra, xfer_rvalid, operand_error, e;
	fprf_xfer_t xfer_kind;
	logic [3:0] xfer_field, core_nzcv;
	logic [3:0] cmp_nzcv = 4'h0;
	logic [31:0] xfer_wdata0, xfer_wdata1, xfer_rdata0, xfer_rdata1, q0, q1;
	logic [31:0] lsm_rdata, fp_status_control_reg;
	logic vec_valid = 1'b0, vec_is_dbl = 1'b0, vec_is_div = 1'b0;
	logic vec_ready, elem_valid, elem_dbl, elem_div, elem_a_sign, mac_div_busy;
	logic [4:0] vec_dst = 5'h0, vec_src_a = 5'h0, vec_src_b = 5'h0, lsm_base = 5'h0;
	logic [4:0] res_idx = 5'h0, ds_idx = 5'h0, elem_dst;
	logic [63:0] res_data = 64'h0, ds_data = 64'h0, elem_opa, elem_opb;
	logic [10:0] elem_a_exp;
	logic lsm_start = 1'b0, res_valid = 1'b0, res_dbl = 1'b0, ds_valid = 1'b0, ds_dbl = 1'b0;
	logic ds_busy = 1'b0;
	logic cmp_valid = 1'b0, flag_xfer_valid = 1'b0, lsm_busy, lsm_rvalid, flag_xfer_done;
	logic [5:0] lsm_count = 6'h0;
	int mismatches = 0;
	int total_checks = 0;
	fprf_top dut (.clock, .rst, .xfer_valid, .xfer_ready, .xfer_write, .xfer_kind,
		.xfer_field, .xfer_extra, .xfer_wdata0, .xfer_wdata1, .xfer_rvalid, .xfer_rdata0,
		.xfer_rdata1, .operand_error, .vec_valid, .vec_ready, .vec_is_dbl, .vec_is_div,
		.vec_dst, .vec_src_a, .vec_src_b, .elem_valid, .elem_dbl, .elem_div, .elem_dst,
		.elem_opa, .elem_opb, .elem_a_sign, .elem_a_exp, .mac_div_busy, .lsm_start,
		.lsm_load(1'b0), .lsm_base, .lsm_count, .lsm_busy, .lsm_wvalid(1'b0),
		.lsm_wdata(32'h0), .lsm_rvalid, .lsm_rdata, .res_valid, .res_dbl, .res_idx,
		.res_data, .ds_valid, .ds_dbl, .ds_idx, .ds_data, .ds_busy, .cmp_valid,
		.cmp_nzcv, .flag_xfer_valid, .flag_xfer_done, .core_nzcv, .fp_status_control_reg);
	fprf_host_model host (.clock, .xfer_valid, .xfer_ready, .xfer_write, .xfer_kind,
		.xfer_field, .xfer_extra, .xfer_wdata0, .xfer_wdata1, .xfer_rvalid, .xfer_rdata0,
		.xfer_rdata1, .operand_error);
	// 200 MHz core clock
	always #2.5 clock = ~clock;
	// -------
	// helpers
	// -------
	// pattern per register: sign and exponent fields differ from register to register
	function automatic logic [31:0] val(input logic [4:0] i);
		return {i[0], 2'h1, i, 19'h0, i};
	endfunction : val
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic set_ctrl(input logic [1:0] s, input logic [2:0] l);
		logic [31:0] cw;
		cw = {10'h0, s, 1'b0, l, 16'h0};
		host.xfer(1'b1, X_CTRL, 5'h0, cw, 32'h0, q0, q1, e);
		host.xfer(1'b0, X_CTRL, 5'h0, 32'h0, 32'h0, q0, q1, e);
		chk(q0, cw);
	endtask : set_ctrl
	// one vector issue; elements checked as they stream out, indices wrap in the bank
	task automatic vec_run(input logic dbl, input logic div, input logic [4:0] d,
		input logic [4:0] a, input int n, input int stp);
		int w;
		logic [4:0] ed, ea;
		logic [31:0] vl, vh;
		w = 0;
		@(posedge clock);
		#1;
		vec_valid = 1'b1;
		vec_is_dbl = dbl;
		vec_is_div = div;
		vec_dst = d;
		vec_src_a = a;
		vec_src_b = a;
		@(posedge clock);
		#1;
		vec_valid = 1'b0;
		vec_dst = ~d;
		vec_src_a = ~a;
		vec_src_b = ~a;
		do @(negedge clock); while (!elem_valid && ++w < 8);
		for (int k = 0; k < n; k++) begin
			ed = {d[4:3], 3'(d[2:0] + k * stp)};
			ea = {a[4:3], 3'(a[2:0] + k * stp)};
			vl = val(ea);
			vh = val(5'(ea + 5'h1));
			chk(elem_valid, 1'b1);
			chk(elem_dst, ed);
			chk({elem_dbl, elem_div}, {dbl, div});
			if (dbl) chk(elem_opa, {vh, vl});
			if (dbl) chk({elem_a_sign, elem_a_exp}, {vh[31], vh[30:20]});
			if (!dbl) chk(elem_opa[31:0], vl);
			if (!dbl) chk({elem_a_sign, elem_a_exp}, {vl[31], 3'h0, vl[30:23]});
			if (div && k < n - 1) chk(mac_div_busy, 1'b1);
			@(negedge clock);
		end
		chk(elem_valid, 1'b0);
	endtask : vec_run
	// store multiple, read one word per cycle
	task automatic lsm_store(input logic [4:0] b, input int n);
		int w;
		repeat (2) @(posedge clock);
		#1;
		lsm_start = 1'b1;
		lsm_base = b;
		lsm_count = 6'(n);
		@(posedge clock);
		#1;
		lsm_start = 1'b0;
		lsm_base = ~b;
		for (int k = 0; k < n; k++) begin
			w = 0;
			do @(negedge clock); while (!lsm_rvalid && ++w < 8);
			if (k == 0) chk(elem_valid, 1'b1);
			chk(lsm_rdata, val(5'(b + k)));
		end
	endtask : lsm_store
	// ---------
	// scenarios
	// ---------
	task automatic t_xfer();
		chk(fp_status_control_reg, 32'h0);
		for (int i = 0; i < 32; i += 2)
			host.xfer(1'b1, X_PAIR, 5'(i), val(5'(i)), val(5'(i + 1)), q0, q1, e);
		for (int i = 0; i < 32; i++) begin
			host.xfer(1'b0, X_SGL, 5'(i), 32'h0, 32'h0, q0, q1, e);
			chk(q0, val(5'(i)));
		end
		for (int i = 0; i < 32; i += 2) begin
			host.xfer(1'b0, X_DBL, 5'(i), 32'h0, 32'h0, q0, q1, e);
			chk({q1, q0}, {val(5'(i + 1)), val(5'(i))});
		end
		host.xfer(1'b0, X_HI, 5'h4, 32'h0, 32'h0, q0, q1, e);
		chk(q0, val(5'h5));
		for (int j = 1; j < 4; j++) begin
			host.xfer(1'b1, fprf_xfer_t'(j), 5'h5, 32'h0, 32'h0, q0, q1, e);
			chk(e, 1'b1);
		end
		host.xfer(1'b0, X_PAIR, 5'h5, 32'h0, 32'h0, q0, q1, e);
		chk({q1, q0}, {val(5'h6), val(5'h5)});
		$display("test transfers done");
	endtask : t_xfer
	task automatic t_vec();
		set_ctrl(2'h0, 3'h3);
		fork
			vec_run(1'b0, 1'b0, 5'd14, 5'd22, 4, 1);
			lsm_store(5'd6, 4);
		join
		set_ctrl(2'h3, 3'h7);
		vec_run(1'b0, 1'b0, 5'd16, 5'd2, 8, 2);
		set_ctrl(2'h0, 3'h7);
		vec_run(1'b1, 1'b0, 5'd0, 5'd8, 4, 2);
		set_ctrl(2'h0, 3'h2);
		fork
			vec_run(1'b0, 1'b1, 5'd24, 5'd24, 3, 1);
			host.xfer(1'b0, X_CTRL, 5'h0, 32'h0, 32'h0, q0, q1, e);
			begin
				repeat (2) @(negedge clock);
				chk(xfer_ready, 1'b0);
			end
		join
		chk(q0, 32'h0002_0000);
		chk(mac_div_busy, 1'b0);
		// divide unit busy holds back a control read
		@(posedge clock);
		#1;
		ds_busy = 1'b1;
		fork
			host.xfer(1'b0, X_CTRL, 5'h0, 32'h0, 32'h0, q0, q1, e);
			begin
				repeat (3) @(negedge clock);
				chk(xfer_ready, 1'b0);
				@(posedge clock);
				#1;
				ds_busy = 1'b0;
			end
		join
		chk(q0, 32'h0002_0000);
		$display("test vectors done");
	endtask : t_vec
	task automatic t_wb_flags();
		int w;
		@(posedge clock);
		#1;
		res_valid = 1'b1;
		res_idx = 5'd3;
		res_data = 64'h0000_0000_8765_4321;
		ds_valid = 1'b1;
		ds_dbl = 1'b1;
		ds_idx = 5'd26;
		ds_data = 64'hc000_0001_0000_0002;
		@(posedge clock);
		#1;
		res_valid = 1'b0;
		ds_valid = 1'b0;
		res_data = ~res_data;
		ds_data = ~ds_data;
		host.xfer(1'b0, X_SGL, 5'd3, 32'h0, 32'h0, q0, q1, e);
		chk(q0, 32'h8765_4321);
		host.xfer(1'b0, X_DBL, 5'd26, 32'h0, 32'h0, q0, q1, e);
		chk({q1, q0}, 64'hc000_0001_0000_0002);
		for (int j = 0; j < 2; j++) begin
			@(posedge clock);
			#1;
			cmp_valid = 1'b1;
			cmp_nzcv = j ? 4'ha : 4'h5;
			@(posedge clock);
			#1;
			cmp_valid = 1'b0;
			flag_xfer_valid = 1'b1;
			@(posedge clock);
			#1;
			flag_xfer_valid = 1'b0;
			w = 0;
			while (!flag_xfer_done && w < 4) begin
				@(negedge clock);
				w++;
			end
			chk(flag_xfer_done, 1'b1);
			chk({core_nzcv, fp_status_control_reg[31:28]}, {cmp_nzcv, cmp_nzcv});
		end
		$display("test write-back and flags done");
	endtask : t_wb_flags
	// main sequence: two cycles of reset, then every scenario in turn
	initial begin
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		t_xfer();
		t_vec();
		t_wb_flags();
		wrap_up();
	end
	// watchdog: far beyond the few hundred cycles the scenarios need
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule : fprf_top_tb
`default_nettype wire
